// [hw/rcmr_top.sv]
// Reset cause recorder and bottom-of-map memory alias, AHB-Lite slave.
// Assumes the system reset tree drives hresetn from all four reset sources
// and por_n only from power-on; wdt_expired comes from hclk logic.
//
// Design decision made here: register access over AHB-Lite.
`include "rcmr_params.svh"

module rcmr_top
    import rcmr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        por_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        wdt_expired,
    input  wire logic        boot_mode_pin,
    input  wire logic        cfg_done,
    input  wire logic [31:0] fetch_addr,
    output logic             alias_sram,
    output logic             fetch_sram,
    output logic             sw_reset_req,
    output logic             user_start,
    output logic             irq
);

    rcmr_state_t  q;
    rcmr_state_t  d;
    logic         sw_set_c;
    logic [2:0]   clr_mask_c;
    logic [1:0]   ev_c;
    logic [1:0]   sts_clr_c;
    logic         wr_c;
    logic         take_c;

    rcmr_cause_if cif ();

    rcmr_cause u_cause (
        .hclk  (hclk),
        .por_n (por_n),
        .cif   (cif)
    );

    assign cif.wdt_evt  = wdt_expired;
    assign cif.sw_set   = sw_set_c;
    assign cif.clr_mask = clr_mask_c;

    // -------------------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------------------
    // Reads use next-cycle values, so a write followed directly by a read of
    // the same register returns the new contents.
    function automatic logic [31:0] rd_word(input logic [31:0] a,
                                            input rcmr_state_t s,
                                            input logic [2:0] flags);
        logic [31:0] v;
        v = 32'h00000000;
        case (a)
            `RCMR_ADDR_ALIAS: begin
                v[`RCMR_ALIAS_BIT]       = s.alias_sram;
                v[`RCMR_SRAM_SMALL_BIT]  = `RCMR_SRAM_SMALL;
                v[`RCMR_FLASH_SMALL_BIT] = `RCMR_FLASH_SMALL;
            end
            `RCMR_ADDR_CAUSE: begin
                v[2:0] = flags;
            end
            `RCMR_ADDR_IRQ_STS: begin
                v[1:0] = s.irq_sts;
            end
            `RCMR_ADDR_IRQ_MASK: begin
                v[1:0] = s.irq_mask;
            end
            default: begin
                v = 32'h00000000;
            end
        endcase
        return v;
    endfunction

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        d          = q;
        sw_set_c   = 1'b0;
        clr_mask_c = 3'h0;
        ev_c       = 2'h0;
        sts_clr_c  = 2'h0;
        d.hreadyout  = 1'b1;
        d.rst_seen   = 1'b1;
        d.user_start = 1'b0;
        d.bm_meta    = boot_mode_pin;
        d.bm_sync    = q.bm_meta;

        wr_c = q.ap_valid && q.ap_write;
        if (wr_c) begin
            case (q.ap_addr)
                `RCMR_ADDR_ALIAS: begin
                    // Bit 0 alone is writable; size bits are straps.
                    d.alias_sram = hwdata[`RCMR_ALIAS_BIT];
                    ev_c[`RCMR_EV_ALIAS] = (hwdata[`RCMR_ALIAS_BIT] != q.alias_sram);
                end
                `RCMR_ADDR_CAUSE: begin
                    // Power-on and watchdog bits are set by hardware only.
                    if (hwdata[`RCMR_CAUSE_SW]) begin
                        sw_set_c       = 1'b1;
                        d.sw_reset_req = 1'b1;
                    end
                end
                `RCMR_ADDR_CLEAR: begin
                    clr_mask_c = hwdata[2:0];
                end
                `RCMR_ADDR_IRQ_STS: begin
                    sts_clr_c = hwdata[1:0];
                end
                `RCMR_ADDR_IRQ_MASK: begin
                    d.irq_mask = hwdata[1:0];
                end
                default: begin
                    d.irq_mask = q.irq_mask;
                end
            endcase
        end

        // The kernel raises cfg_done; with boot_mode_pin high, user code starts once after each system reset at vector zero.
        if (cfg_done && q.bm_sync && !q.started) begin
            d.started         = 1'b1;
            d.user_start      = 1'b1;
            ev_c[`RCMR_EV_BOOT] = 1'b1;
        end

        d.irq_sts = (q.irq_sts & ~sts_clr_c) | ev_c;
        d.irq     = |(d.irq_sts & d.irq_mask);

        // Registered steering for the fetch path, one cycle behind the address.
        d.fetch_sram = d.alias_sram && (fetch_addr <= `RCMR_ALIAS_TOP);

        take_c     = hsel && htrans[1] && hready;
        d.ap_valid = take_c;
        d.ap_write = hwrite;
        d.ap_addr  = haddr;
        if (take_c && !hwrite) begin
            d.hrdata = rd_word(haddr, d, cif.flags_nx);
        end else begin
            d.hrdata = 32'h00000000;
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    // Every system reset lands here, so the alias always falls back to program
    // memory and any pending software reset request is withdrawn.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.hreadyout <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata       = q.hrdata;
    assign hreadyout    = q.hreadyout;
    assign hresp        = 1'b0;
    assign alias_sram   = q.alias_sram;
    assign fetch_sram   = q.fetch_sram;
    assign sw_reset_req = q.sw_reset_req;
    assign user_start   = q.user_start;
    assign irq          = q.irq;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_reset_alias: assert property ($rose(q.rst_seen) |-> !q.alias_sram)
        else $error("alias not cleared after reset");
    a_alias_set: assert property (
        (wr_c && q.ap_addr == `RCMR_ADDR_ALIAS && hwdata[0]) |=> q.alias_sram)
        else $error("alias write of one did not select SRAM");
    a_alias_clear: assert property (
        (wr_c && q.ap_addr == `RCMR_ADDR_ALIAS && !hwdata[0]) |=> !q.alias_sram)
        else $error("alias write of zero did not restore program memory");
    a_fetch_region: assert property (
        (q.alias_sram && fetch_addr > `RCMR_ALIAS_TOP) |=> !q.fetch_sram)
        else $error("fetch above the vector region steered to SRAM");
    a_size_bits: assert property (
        (take_c && !hwrite && haddr == `RCMR_ADDR_ALIAS)
        |=> q.hrdata[4:3] == {`RCMR_FLASH_SMALL, `RCMR_SRAM_SMALL} && q.hrdata[2:1] == 2'h0)
        else $error("alias register size bits wrong");
    a_sw_request: assert property (
        (wr_c && q.ap_addr == `RCMR_ADDR_CAUSE && hwdata[2])
        |=> sw_reset_req && cif.flags[`RCMR_CAUSE_SW])
        else $error("software reset not requested or not recorded");
    a_boot_start: assert property (
        user_start |-> $past(cfg_done) && $past(q.bm_sync) ##1 !user_start)
        else $error("user start without boot mode and configuration");
    a_irq_level: assert property (irq == |(q.irq_sts & q.irq_mask))
        else $error("interrupt level disagrees with unmasked status");
    c_alias_sram: cover property (q.alias_sram && fetch_sram);
    c_sw_reset: cover property (sw_reset_req);
    c_boot: cover property (user_start);

endmodule // rcmr_top

// [inc/rcmr_params.svh]
// Constants for the reset cause and memory alias block.
// Assumes a 32-bit AHB-Lite bus clocked by hclk at 20 MHz.
`ifndef RCMR_PARAMS_SVH
`define RCMR_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define RCMR_ADDR_ALIAS     32'hffff0220
`define RCMR_ADDR_CAUSE     32'hffff0230
`define RCMR_ADDR_CLEAR     32'hffff0234
`define RCMR_ADDR_IRQ_STS   32'hffff0238
`define RCMR_ADDR_IRQ_MASK  32'hffff023c

// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define RCMR_ALIAS_BIT      0
`define RCMR_SRAM_SMALL_BIT 3
`define RCMR_FLASH_SMALL_BIT 4
`define RCMR_CAUSE_POR      0
`define RCMR_CAUSE_WDT      1
`define RCMR_CAUSE_SW       2
`define RCMR_CAUSE_RESET    3'h1
`define RCMR_EV_ALIAS       0
`define RCMR_EV_BOOT        1
`define RCMR_ALIAS_TOP      32'h00000020
`define RCMR_SAFE_BASE      32'h00080020
`define RCMR_FLASH_SMALL    1'h0
`define RCMR_SRAM_SMALL     1'h0

`endif

// [inc/rcmr_pkg.sv]
// Types shared by the reset cause and memory alias block.
// Assumes rcmr_params.svh is on the include path.
package rcmr_pkg;

    typedef struct packed {
        logic        ap_valid;
        logic        ap_write;
        logic [31:0] ap_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        rst_seen;
        logic        alias_sram;
        logic        sw_reset_req;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_mask;
        logic        irq;
        logic        bm_meta;
        logic        bm_sync;
        logic        started;
        logic        user_start;
        logic        fetch_sram;
    } rcmr_state_t;

    typedef struct packed {
        logic [2:0] flags;
    } rcmr_cause_t;

endpackage : rcmr_pkg

// [inc/rcmr_cause_if.sv]
// Link between the bus side and the power-on domain cause flags.
// Both ends run on hclk.
interface rcmr_cause_if;
    logic       wdt_evt;
    logic       sw_set;
    logic [2:0] clr_mask;
    logic [2:0] flags;
    logic [2:0] flags_nx;

    modport ctrl (output wdt_evt, output sw_set, output clr_mask,
                  input flags, input flags_nx);
    modport cause (input wdt_evt, input sw_set, input clr_mask,
                   output flags, output flags_nx);
endinterface : rcmr_cause_if

// [hw/rcmr_cause.sv]
// Reset cause flags, kept in the power-on reset domain.
// Assumes por_n is only asserted by the power-on detector.
`include "rcmr_params.svh"

module rcmr_cause
    import rcmr_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  por_n,
    rcmr_cause_if.cause cif
);

    rcmr_cause_t q;
    rcmr_cause_t d;

    // -------------------------------------------------------------------------
    // Flag update
    // -------------------------------------------------------------------------
    // Sets win over a clear landing in the same cycle, so no cause is lost.
    always_comb begin
        d = q;
        d.flags = q.flags & ~cif.clr_mask;
        if (cif.wdt_evt) begin
            d.flags[`RCMR_CAUSE_WDT] = 1'b1;
        end
        if (cif.sw_set) begin
            d.flags[`RCMR_CAUSE_SW] = 1'b1;
        end
    end

    // Only power-on reaches this register; other resets leave the record alone.
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            q.flags <= `RCMR_CAUSE_RESET;
        end else begin
            q <= d;
        end
    end

    assign cif.flags    = q.flags;
    assign cif.flags_nx = d.flags;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!por_n);

    a_wdt_sets: assert property (cif.wdt_evt |=> q.flags[`RCMR_CAUSE_WDT])
        else $error("watchdog event did not set its cause bit");
    a_clear_works: assert property (
        (cif.clr_mask == 3'h7 && !cif.wdt_evt && !cif.sw_set) |=> q.flags == 3'h0)
        else $error("full clear mask left cause bits set");
    a_ext_keeps: assert property (
        (cif.clr_mask == 3'h0 && !cif.wdt_evt && !cif.sw_set) |=> $stable(q.flags))
        else $error("cause bits changed without a cause");
    c_all_clear: cover property (q.flags == 3'h0);

endmodule // rcmr_cause

// [tb/rcmr_sys_model.sv]
// Behavioural model of the reset tree and watchdog around the block.
// Assumes the bench asks for power-on, external and watchdog resets on hclk.
module rcmr_sys_model (
    input  wire logic hclk,
    input  wire logic pwr_rst_n,
    input  wire logic ext_rst_n,
    input  wire logic wdt_fire,
    input  wire logic sw_reset_req,
    output logic      por_n,
    output logic      hresetn,
    output logic      wdt_expired
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] hold_q = 2'h0;
    logic       trip_q = 1'b0;
    logic       wdt_q  = 1'b0;

    // The trip is reported two cycles before the reset it causes, so that the
    // block can record the cause while it still has a clocked domain.
    always @(posedge hclk) begin
        wdt_q <= wdt_fire;
        trip_q <= wdt_q;
        if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else if (sw_reset_req || trip_q) begin
            hold_q <= 2'h3;
        end
    end

    assign wdt_expired = wdt_q;
    assign por_n   = pwr_rst_n;
    assign hresetn = pwr_rst_n && ext_rst_n && (hold_q == 2'h0);
endmodule // rcmr_sys_model

// [tb/test_reset_cause_and_memory_remap.sv]
// Self-checking bench for the reset cause recorder and memory alias block.
// Assumes rcmr_params.svh on the include path and a single AHB-Lite slave.
`include "rcmr_params.svh"

module test_reset_cause_and_memory_remap;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] AL = `RCMR_ADDR_ALIAS;
    localparam logic [31:0] CA = `RCMR_ADDR_CAUSE;
    localparam logic [31:0] CL = `RCMR_ADDR_CLEAR;
    localparam logic [31:0] ST = `RCMR_ADDR_IRQ_STS;
    localparam logic [31:0] MK = `RCMR_ADDR_IRQ_MASK;
    localparam logic [31:0] SF = `RCMR_SAFE_BASE + 32'h4;
    localparam logic [31:0] SZ = {27'h0, `RCMR_FLASH_SMALL, `RCMR_SRAM_SMALL, 3'h0};

    logic        hclk, pwr_rst_n, ext_rst_n, wdt_fire, hresetn, por_n, wdt_expired;
    logic        hsel, hwrite, hready, hreadyout, hresp, boot_mode_pin, cfg_done;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, fetch_addr;
    logic        alias_sram, fetch_sram, sw_reset_req, user_start, irq;
    int          miscompares = 0;
    int          comparisons = 0;
    int          starts = 0;

    assign hready = hreadyout;

    rcmr_top dut (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wdt_expired(wdt_expired), .boot_mode_pin(boot_mode_pin), .cfg_done(cfg_done),
        .fetch_addr(fetch_addr), .alias_sram(alias_sram), .fetch_sram(fetch_sram),
        .sw_reset_req(sw_reset_req), .user_start(user_start), .irq(irq));

    rcmr_sys_model sys (
        .hclk(hclk), .pwr_rst_n(pwr_rst_n), .ext_rst_n(ext_rst_n), .wdt_fire(wdt_fire),
        .sw_reset_req(sw_reset_req), .por_n(por_n), .hresetn(hresetn),
        .wdt_expired(wdt_expired));

    // -------------------------------------------------------------------------
    // Bus and check tasks
    // -------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic xfer(input logic [31:0] addr, input logic wr, input logic [31:0] data);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        wait_ready();
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        xfer(addr, 1'b1, data);
        @(negedge hclk);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        xfer(addr, 1'b0, 32'h0);
        check(hrdata, exp);
    endtask

    task automatic fetch(input logic [31:0] addr, input logic exp);
        @(posedge hclk);
        fetch_addr <= addr;
        @(posedge hclk);
        @(negedge hclk);
        check(32'(fetch_sram), 32'(exp));
    endtask

    task automatic wait_reset();
        repeat (4) @(posedge hclk);
        while (hresetn !== 1'b1) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        if (user_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Generous limit: the whole sequence needs well under a thousand cycles.
    initial begin
        #500000;
        miscompares++;
        summarize();
    end

    // -------------------------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------------------------
    initial begin
        {pwr_rst_n, ext_rst_n, wdt_fire, hsel, hwrite, boot_mode_pin, cfg_done} = 7'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        fetch_addr = 32'h0;
        repeat (4) @(posedge hclk);
        pwr_rst_n <= 1'b1;
        ext_rst_n <= 1'b1;
        cfg_done <= 1'b1;
        repeat (6) @(posedge hclk);
        check(starts, 0);
        boot_mode_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        check(starts, 1);
        rd(CA, 32'h1);
        rd(AL, SZ);
        rd(CL, 32'h0);
        rd(32'hffff0300, 32'h0);
        check(32'(hresp), 32'h0);
        fetch(32'h0, 1'b0);
        // The first alias swap is made while the core runs above the mirrored region.
        fetch(SF, 1'b0);
        wr(AL, 32'hffffffff);
        check(32'(alias_sram), 32'h1);
        rd(AL, SZ | 32'h1);
        fetch(32'h20, 1'b1);
        fetch(32'h24, 1'b0);
        fetch(SF, 1'b0);
        wr(AL, 32'h0);
        check(32'(alias_sram), 32'h0);
        fetch(32'h0, 1'b0);
        // Alias change and boot start both left sticky events behind.
        rd(ST, 32'h3);
        check(32'(irq), 32'h0);
        wr(MK, 32'h1);
        check(32'(irq), 32'h1);
        wr(ST, 32'h1);
        check(32'(irq), 32'h0);
        wr(MK, 32'h2);
        check(32'(irq), 32'h1);
        wr(ST, 32'h2);
        check(32'(irq), 32'h0);
        rd(ST, 32'h0);
        wr(CA, 32'h3);
        rd(CA, 32'h1);
        wr(CL, 32'h7);
        rd(CA, 32'h0);
        wr(AL, 32'h1);
        @(posedge hclk);
        wdt_fire <= 1'b1;
        @(posedge hclk);
        wdt_fire <= 1'b0;
        wait_reset();
        check(32'(alias_sram), 32'h0);
        rd(CA, 32'h2);
        rd(AL, SZ);
        wr(CL, 32'h2);
        rd(CA, 32'h0);
        wr(AL, 32'h1);
        wr(CA, 32'h4);
        check(32'(sw_reset_req), 32'h1);
        wait_reset();
        check(32'(alias_sram), 32'h0);
        rd(CA, 32'h4);
        wr(CL, 32'h4);
        check(starts, 3);
        wr(AL, 32'h1);
        @(posedge hclk);
        ext_rst_n <= 1'b0;
        repeat (4) @(posedge hclk);
        ext_rst_n <= 1'b1;
        @(negedge hclk);
        check(32'(alias_sram), 32'h0);
        rd(CA, 32'h0);
        summarize();
    end
endmodule // test_reset_cause_and_memory_remap
